// ===== eeprom_pkg.sv
// Overview of operation
// RULE1: mode 00 erase+write, 01 erase only, 10 write only, 11 reserved.
// RULE2: mode bits ignore software writes while the program strobe is set.
// RULE3: reset returns mode bits to 00 unless programming is still busy.
// RULE4: ready interrupt needs enable bit and global interrupt flag both set.
// RULE5: enabled ready interrupt is a level, asserted while program strobe clear.
// RULE6: strobe set within four cycles of master enable starts programming.
// RULE7: strobe set with master enable clear starts nothing.
// RULE8: master enable clears itself four clock cycles after being written one.
// RULE9: software polls strobe and flash busy, arms master enable, then strobes.
// RULE10: no array programming may start while flash self-programming is active.
// RULE11: hardware clears the program strobe when programming time elapses.
// RULE12: setting the program strobe stalls the cpu for two cycles.
// RULE13: read strobe fetches the addressed byte into the data register at once; the code loads it two clock edges after the strobe write.
// RULE14: a read stalls the cpu for four cycles.
// RULE15: while programming, reads are refused and the address is locked.
// RULE16: programming time counts oscillator ticks, 26368 for a full write.
// RULE17: software should hold interrupts off across the write sequence.
// RULE18: software should wait for strobe clear before reading.
// RULE19: address is twelve bits, upper four bits of high byte read zero.
// RULE20: data register feeds writes and receives read results.
// RULE21: control bits 7 and 6 read zero and ignore writes.
// RULE22: reserved mode 11 starts nothing and leaves the strobe clear.
package eeprom_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int IO_AW  = 2;

    // io offsets of the four byte registers
    localparam logic [IO_AW-1:0] OFS_CONTROL = 2'h0;
    localparam logic [IO_AW-1:0] OFS_DATA    = 2'h1;
    localparam logic [IO_AW-1:0] OFS_ADDR_LO = 2'h2;
    localparam logic [IO_AW-1:0] OFS_ADDR_HI = 2'h3;

    // control register fields
    localparam int BIT_READ_STROBE    = 0;
    localparam int BIT_PROGRAM_STROBE = 1;
    localparam int BIT_MASTER_ENABLE  = 2;
    localparam int BIT_READY_IRQ_EN   = 3;
    localparam int BIT_MODE_LO        = 4;
    localparam int BIT_MODE_HI        = 5;
    localparam int ADDR_HI_BITS       = ADDR_W - DATA_W;

    localparam logic [1:0] MODE_ATOMIC   = 2'h0;
    localparam logic [1:0] MODE_ERASE    = 2'h1;
    localparam logic [1:0] MODE_WRITE    = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    localparam logic [1:0]        MODE_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // cpu clock cycles
    localparam logic [2:0] MASTER_WINDOW = 3'h4;
    localparam logic [2:0] PROG_STALL    = 3'h2;
    localparam logic [2:0] READ_STALL    = 3'h4;

    // programming time in milliseconds and in oscillator ticks
    localparam real ATOMIC_TIME_MS   = 3.4;
    localparam real SPLIT_TIME_MS    = 1.8;
    localparam real WRITE_TYP_MS     = 3.3;
    localparam int  WRITE_OSC_CYCLES = 26368;
    localparam int  ATOMIC_OSC_CYCLES = WRITE_OSC_CYCLES;
    localparam int  SPLIT_OSC_CYCLES =
        int'($ceil(SPLIT_TIME_MS * real'(WRITE_OSC_CYCLES) / WRITE_TYP_MS));
    localparam int  TICK_W = 15;

    typedef enum logic {
        PS_IDLE = 1'b0,
        PS_BUSY = 1'b1
    } prog_state_t;

endpackage : eeprom_pkg

// ===== nvm_prog_timer.sv
`timescale 1ns/1ps
module nvm_prog_timer #(
    parameter int TICK_W       = eeprom_pkg::TICK_W,
    parameter int ATOMIC_TICKS = eeprom_pkg::ATOMIC_OSC_CYCLES,
    parameter int SPLIT_TICKS  = eeprom_pkg::SPLIT_OSC_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic por,
    input  wire logic ce,
    input  wire logic start,
    input  wire logic atomic,
    input  wire logic rc_tick,
    output logic      done
);

    logic [TICK_W-1:0] remaining;
    logic [TICK_W-1:0] next_remaining;
    logic              running;
    wire  logic        last_tick;

    // only power-on clears it: a cpu reset must not cut programming short
    assign last_tick = running && rc_tick && (remaining == TICK_W'(1));

    always_comb begin
        next_remaining = remaining;
        if (start) begin
            next_remaining = atomic ? TICK_W'(ATOMIC_TICKS)
                                    : TICK_W'(SPLIT_TICKS); // RULE16
        end else if (running && rc_tick) begin
            next_remaining = remaining - TICK_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por) begin
            remaining <= '0;
            running   <= 1'b0;
            done      <= 1'b0;
        end else if (ce) begin
            remaining <= next_remaining;
            running   <= start || (running && !last_tick);
            done      <= last_tick;
        end
    end

endmodule : nvm_prog_timer

// ===== eeprom_access_control.sv
`timescale 1ns/1ps
module eeprom_access_control #(
    parameter int ATOMIC_TICKS = eeprom_pkg::ATOMIC_OSC_CYCLES,
    parameter int SPLIT_TICKS  = eeprom_pkg::SPLIT_OSC_CYCLES
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          por,
    input  wire logic                          ce,
    input  wire logic [eeprom_pkg::IO_AW-1:0]  io_addr,
    input  wire logic                          io_wr,
    input  wire logic                          io_rd,
    input  wire logic [eeprom_pkg::DATA_W-1:0] io_wdata,
    output logic      [eeprom_pkg::DATA_W-1:0] io_rdata,
    input  wire logic                          global_irq_flag,
    input  wire logic                          self_program_enable,
    input  wire logic                          rc_tick,
    output logic      [eeprom_pkg::ADDR_W-1:0] arr_addr,
    output logic      [eeprom_pkg::DATA_W-1:0] arr_wdata,
    input  wire logic [eeprom_pkg::DATA_W-1:0] arr_rdata,
    output logic                               arr_read,
    output logic                               arr_erase,
    output logic                               arr_write,
    output logic                               ready_irq,
    output logic                               cpu_stall
);

    eeprom_pkg::prog_state_t state;
    eeprom_pkg::prog_state_t next_state;

    logic [1:0]                    program_mode;
    logic [1:0]                    next_program_mode;
    logic                          ready_irq_enable;
    logic                          master_program_enable;
    logic [2:0]                    master_count;
    logic [2:0]                    stall_count;
    logic [2:0]                    next_stall_count;
    logic [eeprom_pkg::ADDR_W-1:0] nvm_address_reg;
    logic [eeprom_pkg::DATA_W-1:0] nvm_data_reg;
    logic [eeprom_pkg::DATA_W-1:0] read_mux;
    logic                          prog_done;

    wire logic program_strobe;
    wire logic wr_control;
    wire logic wr_data;
    wire logic wr_addr_lo;
    wire logic wr_addr_hi;
    wire logic req_program;
    wire logic req_read;
    wire logic req_master;
    wire logic start_go;
    wire logic read_go;
    wire logic mode_atomic;

    // register decode
    assign wr_control = io_wr && (io_addr == eeprom_pkg::OFS_CONTROL);
    assign wr_data    = io_wr && (io_addr == eeprom_pkg::OFS_DATA);
    assign wr_addr_lo = io_wr && (io_addr == eeprom_pkg::OFS_ADDR_LO);
    assign wr_addr_hi = io_wr && (io_addr == eeprom_pkg::OFS_ADDR_HI);

    assign req_program = wr_control
                         && io_wdata[eeprom_pkg::BIT_PROGRAM_STROBE];
    assign req_read    = wr_control && io_wdata[eeprom_pkg::BIT_READ_STROBE];
    assign req_master  = wr_control
                         && io_wdata[eeprom_pkg::BIT_MASTER_ENABLE];

    assign program_strobe = (state == eeprom_pkg::PS_BUSY);

    // mode written alongside the strobe counts for the same write
    always_comb begin
        next_program_mode = program_mode;
        if (wr_control && !program_strobe) begin // RULE2
            next_program_mode = {io_wdata[eeprom_pkg::BIT_MODE_HI],
                                 io_wdata[eeprom_pkg::BIT_MODE_LO]};
        end
    end

    // master enable must already be armed before the strobe write
    // a write during cpu reset must not start the free-running timer
    assign start_go = req_program
                      && !rst
                      && master_program_enable // RULE6 RULE7
                      && !program_strobe
                      && !self_program_enable // RULE10
                      && (next_program_mode
                          != eeprom_pkg::MODE_RESERVED); // RULE22 RULE1

    // a strobe and read in one write: the program start wins
    assign read_go = req_read
                     && !program_strobe // RULE15
                     && !start_go;

    assign mode_atomic = (program_mode == eeprom_pkg::MODE_ATOMIC);

    nvm_prog_timer #(
        .TICK_W       (eeprom_pkg::TICK_W),
        .ATOMIC_TICKS (ATOMIC_TICKS),
        .SPLIT_TICKS  (SPLIT_TICKS)
    ) u_timer (
        .sys_clk (sys_clk),
        .por     (por),
        .ce      (ce),
        .start   (start_go),
        .atomic  (next_program_mode == eeprom_pkg::MODE_ATOMIC),
        .rc_tick (rc_tick),
        .done    (prog_done)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            eeprom_pkg::PS_IDLE: begin
                if (start_go) begin
                    next_state = eeprom_pkg::PS_BUSY;
                end
            end
            eeprom_pkg::PS_BUSY: begin
                if (prog_done) begin
                    next_state = eeprom_pkg::PS_IDLE; // RULE11
                end
            end
        endcase
    end

    // a cpu reset lets a running program cycle finish
    always_ff @(posedge sys_clk) begin
        if (por) begin
            state <= eeprom_pkg::PS_IDLE;
        end else if (rst) begin
            state <= prog_done ? eeprom_pkg::PS_IDLE : state;
        end else if (ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por) begin
            program_mode <= eeprom_pkg::MODE_RESET;
        end else if (rst) begin
            if (!program_strobe) begin
                program_mode <= eeprom_pkg::MODE_RESET; // RULE3
            end
        end else if (ce) begin
            program_mode <= next_program_mode; // RULE1
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            ready_irq_enable <= 1'b0;
        end else if (ce && wr_control) begin
            ready_irq_enable <= io_wdata[eeprom_pkg::BIT_READY_IRQ_EN];
        end
    end

    // master enable: armed by software, dropped after a fixed window
    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            master_program_enable <= 1'b0;
            master_count          <= 3'h0;
        end else if (ce) begin
            if (req_master) begin
                master_program_enable <= 1'b1;
                master_count          <= eeprom_pkg::MASTER_WINDOW;
            end else if (wr_control) begin
                master_program_enable <= 1'b0;
                master_count          <= 3'h0;
            end else if (master_count == 3'h1) begin
                master_program_enable <= 1'b0; // RULE8
                master_count          <= 3'h0;
            end else if (master_count != 3'h0) begin
                master_count <= master_count - 3'h1;
            end
        end
    end

    // cpu halt counter
    always_comb begin
        next_stall_count = stall_count;
        if (start_go) begin
            next_stall_count = eeprom_pkg::PROG_STALL; // RULE12
        end else if (read_go) begin
            next_stall_count = eeprom_pkg::READ_STALL; // RULE14
        end else if (stall_count != 3'h0) begin
            next_stall_count = stall_count - 3'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            stall_count <= 3'h0;
        end else if (ce) begin
            stall_count <= next_stall_count;
        end
    end

    assign cpu_stall = (stall_count != 3'h0);

    // address is frozen while programming so the target cannot move
    always_ff @(posedge sys_clk) begin
        if (por) begin
            nvm_address_reg <= eeprom_pkg::ADDR_RESET;
        end else if (rst) begin
            if (!program_strobe) begin
                nvm_address_reg <= eeprom_pkg::ADDR_RESET;
            end
        end else if (ce && !program_strobe) begin // RULE15
            if (wr_addr_lo) begin
                nvm_address_reg[eeprom_pkg::DATA_W-1:0] <= io_wdata;
            end else if (wr_addr_hi) begin
                nvm_address_reg[eeprom_pkg::ADDR_W-1:eeprom_pkg::DATA_W] <=
                    io_wdata[eeprom_pkg::ADDR_HI_BITS-1:0]; // RULE19
            end
        end
    end

    // read pulse goes out one cycle after the strobe write
    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            arr_read <= 1'b0;
        end else if (ce) begin
            arr_read <= read_go; // RULE13
        end
    end

    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            nvm_data_reg <= eeprom_pkg::DATA_RESET;
        end else if (ce) begin
            if (arr_read) begin
                nvm_data_reg <= arr_rdata; // RULE13 RULE20
            end else if (wr_data) begin
                nvm_data_reg <= io_wdata;
            end
        end
    end

    // write data is latched at start; later data writes do not disturb it
    always_ff @(posedge sys_clk) begin
        if (por) begin
            arr_wdata <= eeprom_pkg::DATA_RESET;
        end else if (ce && start_go) begin
            arr_wdata <= nvm_data_reg; // RULE20
        end
    end

    assign arr_addr  = nvm_address_reg;
    assign arr_erase = program_strobe
                       && (mode_atomic
                           || program_mode == eeprom_pkg::MODE_ERASE);
    assign arr_write = program_strobe
                       && (mode_atomic
                           || program_mode == eeprom_pkg::MODE_WRITE);

    assign ready_irq = ready_irq_enable && global_irq_flag // RULE4
                       && !program_strobe; // RULE5

    // read strobe always reads back zero: it is never stored; the data lands two edges later, under the cpu stall
    always_comb begin
        read_mux = '0;
        unique case (io_addr)
            eeprom_pkg::OFS_CONTROL: begin
                read_mux[eeprom_pkg::BIT_MODE_HI]        = program_mode[1];
                read_mux[eeprom_pkg::BIT_MODE_LO]        = program_mode[0];
                read_mux[eeprom_pkg::BIT_READY_IRQ_EN]   = ready_irq_enable;
                read_mux[eeprom_pkg::BIT_MASTER_ENABLE]  =
                    master_program_enable;
                read_mux[eeprom_pkg::BIT_PROGRAM_STROBE] = program_strobe;
            end
            eeprom_pkg::OFS_DATA: begin
                read_mux = nvm_data_reg;
            end
            eeprom_pkg::OFS_ADDR_LO: begin
                read_mux = nvm_address_reg[eeprom_pkg::DATA_W-1:0];
            end
            eeprom_pkg::OFS_ADDR_HI: begin
                read_mux[eeprom_pkg::ADDR_HI_BITS-1:0] =
                    nvm_address_reg[eeprom_pkg::ADDR_W-1:eeprom_pkg::DATA_W];
            end
        endcase
    end
    // control bits 7..6 never get a value above, so they read zero RULE21

    always_ff @(posedge sys_clk) begin
        if (por || rst) begin
            io_rdata <= '0;
        end else if (ce && io_rd) begin
            io_rdata <= read_mux;
        end
    end

endmodule : eeprom_access_control

// ===== eeprom_access_control_checker.sv
`timescale 1ns/1ps
module eeprom_access_control_checker (
    input wire logic                          sys_clk,
    input wire logic                          rst,
    input wire logic                          por,
    input wire logic                          ce,
    input wire logic [eeprom_pkg::IO_AW-1:0]  io_addr,
    input wire logic                          io_wr,
    input wire logic [eeprom_pkg::DATA_W-1:0] io_wdata,
    input wire logic                          global_irq_flag,
    input wire logic                          self_program_enable,
    input wire logic [eeprom_pkg::ADDR_W-1:0] arr_addr,
    input wire logic [eeprom_pkg::DATA_W-1:0] arr_wdata,
    input wire logic                          arr_read,
    input wire logic                          arr_erase,
    input wire logic                          arr_write,
    input wire logic                          ready_irq,
    input wire logic                          cpu_stall
);
    default clocking cb @(posedge sys_clk); endclocking
    // frozen clock enable would stretch every count, so leave it out
    default disable iff (rst || por || !ce);
    wire busy   = arr_erase | arr_write;
    wire ctl_wr = io_wr && io_addr == eeprom_pkg::OFS_CONTROL;
    wire arm    = ctl_wr && io_wdata[eeprom_pkg::BIT_MASTER_ENABLE];
    wire strobe = ctl_wr && io_wdata[eeprom_pkg::BIT_PROGRAM_STROBE];

    a_irq_needs_gif: assert property (!global_irq_flag |-> !ready_irq)
        else $error("ready irq without global flag");
    a_irq_off_busy: assert property (busy |-> !ready_irq)
        else $error("ready irq while programming");
    a_prog_stall_two: assert property (
        $rose(busy) |-> cpu_stall [*2] ##1 !cpu_stall)
        else $error("program stall length wrong");
    a_read_stall_four: assert property (
        arr_read |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("read stall length wrong");
    a_busy_no_read: assert property (busy |-> !arr_read)
        else $error("array read while programming");
    a_busy_hold_state: assert property (
        busy && $past(busy) |->
        $stable({arr_addr, arr_wdata, arr_erase, arr_write}))
        else $error("address, data or mode moved while busy");
    a_start_mode_map: assert property (
        $rose(busy) |-> arr_erase == !$past(io_wdata[5])
                     && arr_write == !$past(io_wdata[4]))
        else $error("array action does not match mode");
    a_start_cause: assert property (
        $rose(busy) |-> $past(strobe && io_wdata[5:4] != 2'h3
                              && !self_program_enable))
        else $error("programming started without valid strobe");
    a_arm_window: assert property (
        $rose(busy) |-> $past(arm, 2) || $past(arm, 3) || $past(arm, 4)
                        || $past(arm, 5))
        else $error("programming started outside master window");

    c_prog: cover property ($rose(busy));
    c_read: cover property (arr_read);
    c_irq:  cover property (ready_irq);
endmodule : eeprom_access_control_checker

bind eeprom_access_control eeprom_access_control_checker
    eeprom_access_control_checker_i (
    .sys_clk(sys_clk), .rst(rst), .por(por), .ce(ce), .io_addr(io_addr),
    .io_wr(io_wr), .io_wdata(io_wdata), .global_irq_flag(global_irq_flag),
    .self_program_enable(self_program_enable), .arr_addr(arr_addr),
    .arr_wdata(arr_wdata), .arr_read(arr_read), .arr_erase(arr_erase),
    .arr_write(arr_write), .ready_irq(ready_irq), .cpu_stall(cpu_stall));

// ===== eeprom_access_control_tb.sv
`timescale 1ns/1ps
module eeprom_access_control_tb;
    localparam int AT = 20;
    localparam int ST = 10;
    logic        sys_clk, rst, por, ce, io_wr, io_rd;
    logic [1:0]  io_addr;
    logic [7:0]  io_wdata, io_rdata, arr_wdata, arr_rdata, rv;
    logic [11:0] arr_addr;
    logic        global_irq_flag, self_program_enable;
    logic        arr_read, arr_erase, arr_write, ready_irq, cpu_stall;
    logic        rc_tick = 1'b0;
    int          error_cnt, check_count, n;

    eeprom_access_control #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST))
        eeprom_access_control_i (
        .sys_clk(sys_clk), .rst(rst), .por(por), .ce(ce),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_flag(global_irq_flag),
        .self_program_enable(self_program_enable), .rc_tick(rc_tick),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
        .arr_read(arr_read), .arr_erase(arr_erase), .arr_write(arr_write),
        .ready_irq(ready_irq), .cpu_stall(cpu_stall));

    // oscillator ticks every second cycle, so timing is twice the count
    always @(posedge sys_clk) rc_tick <= ~rc_tick;
    // array contents derived from address; garbage outside the read pulse
    assign arr_rdata = arr_read ? arr_addr[7:0] ^ 8'h5a
                                : ~(arr_addr[7:0] ^ 8'h5a);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic step(input int k);
        repeat (k) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : step
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test
    // strobes stay up between back-to-back calls; idle drops them
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        io_wr = 1'b1;
        io_rd = 1'b0;
        io_addr = a;
        io_wdata = d;
        step(1);
    endtask : wr
    task automatic rd(input logic [1:0] a);
        io_rd = 1'b1;
        io_wr = 1'b0;
        io_addr = a;
        step(1);
        rv = io_rdata;
    endtask : rd
    task automatic idle(input int k);
        io_wr = 1'b0;
        io_rd = 1'b0;
        step(k);
    endtask : idle
    task automatic wait_idle;
        n = 0;
        while ((arr_erase | arr_write) !== 1'b0 && n < 300) begin
            step(1);
            n++;
        end
        if (n >= 300) begin
            error_cnt++;
            stop_test();
        end
    endtask : wait_idle
    task automatic cnt_stall(input int exp);
        int c;
        c = 0;
        repeat (6) begin
            if (cpu_stall === 1'b1) c++;
            step(1);
        end
        chk(c, exp);
    endtask : cnt_stall
    task automatic prog(input logic [1:0] m, input logic [11:0] a,
                        input logic [7:0] d);
        global_irq_flag = 1'b0;
        wr(2'h2, a[7:0]);
        wr(2'h3, {4'h0, a[11:8]});
        wr(2'h1, d);
        wr(2'h0, {2'h0, m, 4'hc});
        wr(2'h0, {2'h0, m, 4'ha});
        idle(0);
        global_irq_flag = 1'b1;
    endtask : prog

    task automatic t_irq;
        wr(2'h0, 8'hc8);
        rd(2'h0);
        idle(0);
        chk(rv, 8'h08);
        chk(ready_irq, 1'b1);
        global_irq_flag = 1'b0;
        step(1);
        chk(ready_irq, 1'b0);
        global_irq_flag = 1'b1;
        wr(2'h0, 8'h00);
        idle(0);
        chk(ready_irq, 1'b0);
        ce = 1'b0;
        wr(2'h0, 8'h08);
        idle(0);
        ce = 1'b1;
        chk(ready_irq, 1'b0);
    endtask : t_irq

    task automatic t_modes;
        for (int i = 0; i < 4; i++) begin
            logic [1:0]  m;
            logic [11:0] a;
            int          exp;
            m = i[1:0];
            a = 12'h5a0 | {10'h0, m};
            exp = (m == 2'h0) ? 2 * AT : 2 * ST;
            prog(m, a, 8'h3c ^ {6'h0, m});
            chk({arr_erase, arr_write}, ~m & {2{m != 2'h3}});
            cnt_stall(m == 2'h3 ? 0 : 2);
            chk(ready_irq, m == 2'h3);
            if (m != 2'h3) chk(arr_wdata, 8'h3c ^ {6'h0, m});
            // mode, strobe and address pokes that a busy array must ignore
            wr(2'h0, 8'h3a);
            wr(2'h2, 8'hff);
            rd(2'h0);
            idle(0);
            chk(rv, m == 2'h3 ? 8'h38 : {2'h0, m, 4'ha});
            chk(arr_addr, m == 2'h3 ? 12'h5ff : a);
            wait_idle();
            if (m != 2'h3) chk(n + 9 >= exp - 4 && n + 9 <= exp + 4, 1);
            rd(2'h0);
            idle(0);
            chk(rv, {2'h0, m, 4'h8});
            chk(ready_irq, 1'b1);
        end
    endtask : t_modes

    task automatic t_window;
        wr(2'h0, 8'h04);
        idle(4);
        wr(2'h0, 8'h02);
        idle(1);
        chk({arr_erase, arr_write}, 2'b00);
        wr(2'h0, 8'h04);
        idle(3);
        wr(2'h0, 8'h02);
        idle(0);
        chk({arr_erase, arr_write}, 2'b11);
        wait_idle();
        self_program_enable = 1'b1;
        wr(2'h0, 8'h04);
        wr(2'h0, 8'h02);
        idle(1);
        chk({arr_erase, arr_write}, 2'b00);
        self_program_enable = 1'b0;
    endtask : t_window

    task automatic t_read;
        wait_idle();
        wr(2'h2, 8'h34);
        wr(2'h3, 8'hf7);
        rd(2'h3);
        chk(rv, 8'h07);
        wr(2'h0, 8'h01);
        idle(0);
        cnt_stall(4);
        rd(2'h1);
        chk(rv, 8'h34 ^ 8'h5a);
        rd(2'h0);
        idle(0);
        chk(rv, 8'h00);
    endtask : t_read

    task automatic t_reset;
        prog(2'h2, 12'h211, 8'h99);
        step(4);
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        rd(2'h0);
        idle(0);
        chk(rv, 8'h22);
        chk(arr_addr, 12'h211);
        wait_idle();
        rst = 1'b1;
        step(1);
        rst = 1'b0;
        rd(2'h0);
        idle(0);
        chk(rv, 8'h00);
    endtask : t_reset

    initial begin
        rst = 1'b1;
        por = 1'b1;
        ce = 1'b1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 2'h0;
        io_wdata = 8'h00;
        global_irq_flag = 1'b1;
        self_program_enable = 1'b0;
        error_cnt = 0;
        check_count = 0;
        repeat (4) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        por = 1'b0;
        rd(2'h0);
        chk(rv, 8'h00);
        t_irq();
        t_modes();
        t_window();
        t_read();
        t_reset();
        stop_test();
    end
endmodule : eeprom_access_control_tb
